// ==== rtl/ssf_pkg.sv ====
// ****************************************************************
// serial status flags: shared constants and carriers
// ****************************************************************
package ssf_pkg;

  // ****************************************************************
  // register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [3:0] SSF_OFF_STATUS = 4'h0;
  localparam logic [3:0] SSF_OFF_DATA   = 4'h4;
  localparam logic [3:0] SSF_OFF_CTRL   = 4'h8;

  // ****************************************************************
  // status bit positions and reset values
  // ****************************************************************
  localparam int SSF_BIT_TX_EMPTY = 7;
  localparam int SSF_BIT_TX_DONE  = 6;
  localparam int SSF_BIT_RX_FULL  = 5;
  localparam int SSF_BIT_IDLE    = 4;
  localparam int SSF_BIT_OVERRUN = 3;
  localparam int SSF_BIT_NOISE   = 2;
  localparam int SSF_BIT_FRAME   = 1;
  localparam int SSF_BIT_PARITY  = 0;
  localparam logic [7:0] SSF_STATUS_RESET = 8'hc0;
  localparam logic [7:0] SSF_RX_MASK      = 8'h3f;
  localparam logic [7:0] SSF_TX_MASK      = 8'hc0;
  localparam logic [8:0] SSF_CTRL_RESET   = 9'h000;

  // ****************************************************************
  // idle character time and sampling, in bit times and samples
  // ****************************************************************
  localparam logic [3:0] SSF_IDLE_BITS_8 = 4'ha;
  localparam logic [3:0] SSF_IDLE_BITS_9 = 4'hb;
  localparam int         SSF_START_SAMPLES = 7;
  localparam int         SSF_BIT_SAMPLES   = 3;

  localparam logic [1:0] SSF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SSF_RESP_DECERR = 2'h3;

  // control register, bit 0 upward in declaration order from the bottom
  typedef struct packed {
    logic lin_break_detect_on;
    logic rx_full_irq_on;
    logic tx_empty_irq_on;
    logic idle_count_select;
    logic nine_bit_select;
    logic parity_odd;
    logic parity_on;
    logic tx_on;
    logic send_break_request;
  } ssf_ctrl_t;

  // events from the receive shifter and sampler
  typedef struct packed {
    logic       sample_strobe;
    logic       sample_start;
    logic [6:0] samples;
    logic       bit_tick;
    logic       line;
    logic       start_done;
    logic       stop_done;
    logic       char_ready;
    logic [8:0] data;
    logic       parity_bit;
    logic       stop_bit;
  } ssf_rx_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] arm;
    ssf_ctrl_t  ctrl;
    logic [8:0] rx_data;
    logic [8:0] tx_data;
    logic       noise_acc;
    logic [3:0] idle_cnt;
    logic       idle_run;
    logic       idle_armed;
    logic       done_cond;
    logic       irq;
    logic       aw_have;
    logic       w_have;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ssf_state_t;

endpackage

// ==== rtl/ssf_status_flags.sv ====
// Function
// - tx_buffer_empty_flag sets at reset and when buffer moves into shifter.
// - tx_buffer_empty_flag clears on status read showing it, then data write.
// - tx_complete_flag sets at reset and when buffer empty and shifter idle.
// - tx_complete_flag clears after status read, then data write, tx_on rise or break.
// - rx_buffer_full_flag sets when a received character enters the data register.
// - rx_buffer_full_flag clears on status read showing it, then data read.
// - idle flag sets after a full character time of high line, 10 or 11 bits.
// - idle_count_select 0: idle counting starts right after the start bit.
// - idle_count_select 1: idle counting starts only after the stop bit.
// - idle clears by status then data read; sets again only after new character.
// - overrun sets when new character arrives unread; new character is dropped.
// - overrun clears on status read showing it, then data read.
// - seven start samples, three per bit; disagreement sets noise with full flag.
// - noise clears on status read then data read.
// - framing error sets with full flag when stop bit samples low.
// - framing error clears on status read showing it, then data read.
// - parity error sets with full flag on parity mismatch while parity_on.
// - parity error clears on status read then data read.
// - status register is read only; writes to it change nothing.
// - tx_empty_irq_on raises interrupt request while buffer empty flag is set.
// - rx_full_irq_on raises interrupt request while buffer full flag is set.
// - lin_break_detect_on keeps framing error and buffer full from setting.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
module ssf_status_flags
  import ssf_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  wire  logic                   clk,
  input  wire  logic                   rst,
  // axi4-lite write address and data
  input  wire  logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire  logic                   s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire  logic [31:0]            s_axi_wdata,
  input  wire  logic [3:0]             s_axi_wstrb,
  input  wire  logic                   s_axi_wvalid,
  output logic                         s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire  logic                   s_axi_bready,
  // axi4-lite read
  input  wire  logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire  logic                   s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire  logic                   s_axi_rready,
  // transmit datapath
  input  wire  logic                   tx_load,
  input  wire  logic                   tx_busy,
  output logic [8:0]                   tx_data,
  // receive datapath
  input  wire  ssf_pkg::ssf_rx_t       rx,
  // control and status to the rest of the interface
  output ssf_pkg::ssf_ctrl_t           ctrl,
  output logic [7:0]                   status,
  output logic                         irq_request
);
  import ssf_pkg::*;

  if (ADDR_W != 4) begin : g_check
    $error("ssf_status_flags: ADDR_W must be 4");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic all_same(input logic [6:0] s, input logic start);
    logic [6:0] m;
    m = start ? 7'h7f : 7'h07;
    all_same = ((s & m) == 7'h00) || ((s & m) == m);
  endfunction

  ssf_state_t st;
  ssf_state_t n;

  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic       wr_do;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic       data_wr;
  logic       ctrl_wr;
  logic       stat_wr;
  logic       data_rd;
  logic       stat_rd;
  logic       tx_on_rise;
  logic       brk_wr;
  logic       rx_take;
  logic       rx_lost;
  logic       done_now;
  logic [7:0] set;
  logic [7:0] clr;
  ssf_ctrl_t  wr_ctrl;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  assign aw_hs   = s_axi_awvalid & st.awready;
  assign w_hs    = s_axi_wvalid & st.wready;
  assign ar_hs   = s_axi_arvalid & st.arready;
  // either channel may arrive first; the write acts once both are held
  assign wr_do   = (st.aw_have | aw_hs) & (st.w_have | w_hs) & ~st.bvalid;
  assign wr_addr = st.aw_have ? st.awaddr : s_axi_awaddr;
  assign wr_data = st.w_have ? st.wdata : s_axi_wdata;
  assign wr_strb = st.w_have ? st.wstrb : s_axi_wstrb;
  assign data_wr = wr_do & (wr_addr == SSF_OFF_DATA);
  assign ctrl_wr = wr_do & (wr_addr == SSF_OFF_CTRL);
  assign stat_wr = wr_do & (wr_addr == SSF_OFF_STATUS);
  assign data_rd = ar_hs & (s_axi_araddr == SSF_OFF_DATA);
  assign stat_rd = ar_hs & (s_axi_araddr == SSF_OFF_STATUS);

  always_comb begin
    wr_ctrl = st.ctrl;
    if (wr_strb[0]) begin
      wr_ctrl[7:0] = wr_data[7:0];
    end
    if (wr_strb[1]) begin
      wr_ctrl[8] = wr_data[8];
    end
  end

  assign tx_on_rise = ctrl_wr & wr_ctrl.tx_on & ~st.ctrl.tx_on;
  assign brk_wr     = ctrl_wr & wr_ctrl.send_break_request;

  // ****************************************************************
  // flag events
  // ****************************************************************
  // a character arriving under break detection is neither stored nor flagged
  assign rx_take     = rx.char_ready & ~st.ctrl.lin_break_detect_on &
                       ~st.status[SSF_BIT_RX_FULL];
  assign rx_lost     = rx.char_ready & ~st.ctrl.lin_break_detect_on &
                       st.status[SSF_BIT_RX_FULL];
  // edge of the idle condition, so a pending clear is not undone forever
  assign done_now    = st.status[SSF_BIT_TX_EMPTY] & ~tx_busy;

  always_comb begin
    set = 8'h00;
    set[SSF_BIT_TX_EMPTY] = tx_load;
    set[SSF_BIT_TX_DONE]  = done_now & ~st.done_cond;
    set[SSF_BIT_RX_FULL]  = rx_take;
    set[SSF_BIT_OVERRUN] = rx_lost;
    set[SSF_BIT_NOISE] = rx_take & (st.noise_acc |
                         (rx.sample_strobe & ~all_same(rx.samples, rx.sample_start)));
    set[SSF_BIT_FRAME] = rx_take & ~rx.stop_bit;
    set[SSF_BIT_PARITY] = rx_take & st.ctrl.parity_on &
                          (rx.parity_bit != ((^(rx.data & {st.ctrl.nine_bit_select, 8'hff}))
                                             ^ st.ctrl.parity_odd));
    set[SSF_BIT_IDLE] = st.idle_armed & st.idle_run & (st.idle_cnt ==
                        (st.ctrl.nine_bit_select ? SSF_IDLE_BITS_9 : SSF_IDLE_BITS_8));
    clr = 8'h00;
    clr[SSF_BIT_TX_EMPTY] = data_wr & st.arm[SSF_BIT_TX_EMPTY];
    clr[SSF_BIT_TX_DONE]  = (data_wr | tx_on_rise | brk_wr) & st.arm[SSF_BIT_TX_DONE];
    // one data read clears every armed receive flag
    if (data_rd) begin
      clr = clr | (st.arm & SSF_RX_MASK);
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n = st;
    // status has no write path at all
    n.status = (st.status & ~clr) | set;
    // arm only what the status read saw set; set wins over clear
    n.arm = (st.arm & ~clr) | (stat_rd ? st.status : 8'h00);
    n.done_cond = done_now;
    if (rx_take) begin
      n.rx_data = rx.data;
      n.idle_armed = 1'b1;
    end
    // frame noise: reset by the start bit, gathered over every bit
    if (rx.sample_strobe) begin
      n.noise_acc = (rx.sample_start ? 1'b0 : st.noise_acc) |
                    ~all_same(rx.samples, rx.sample_start);
    end
    if (rx.char_ready) begin
      n.noise_acc = 1'b0;
    end
    // ******** idle line counting ********
    if (rx.start_done) begin
      n.idle_run = ~st.ctrl.idle_count_select;
      n.idle_cnt = 4'h0;
    end else if (rx.stop_done && st.ctrl.idle_count_select) begin
      n.idle_run = 1'b1;
      n.idle_cnt = 4'h0;
    end else if (set[SSF_BIT_IDLE]) begin
      n.idle_armed = 1'b0;
      n.idle_run = 1'b0;
    end else if (st.idle_run && rx.bit_tick) begin
      n.idle_cnt = rx.line ? 4'(st.idle_cnt + 4'h1) : 4'h0;
    end
    if (!rx.line && !rx.start_done) begin
      n.idle_cnt = 4'h0;
    end
    // ******** register writes ********
    if (aw_hs) begin
      n.aw_have = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (wr_do) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (data_wr | ctrl_wr | stat_wr) ? SSF_RESP_OKAY : SSF_RESP_DECERR;
      if (ctrl_wr) begin
        n.ctrl = wr_ctrl;
      end
      if (data_wr) begin
        if (wr_strb[0]) begin
          n.tx_data[7:0] = wr_data[7:0];
        end
        if (wr_strb[1]) begin
          n.tx_data[8] = wr_data[8];
        end
      end
    end else if (st.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    n.awready = ~n.aw_have & ~n.bvalid;
    n.wready = ~n.w_have & ~n.bvalid;
    // ******** register reads ********
    if (ar_hs) begin
      n.rvalid = 1'b1;
      n.rresp = SSF_RESP_OKAY;
      n.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        SSF_OFF_STATUS: n.rdata[7:0] = st.status;
        SSF_OFF_DATA:   n.rdata[8:0] = st.rx_data;
        SSF_OFF_CTRL:   n.rdata[8:0] = st.ctrl;
        default:        n.rresp = SSF_RESP_DECERR;
      endcase
    end else if (st.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    n.arready = ~n.rvalid;
    // ******** interrupt request ********
    n.irq = (n.ctrl.tx_empty_irq_on & n.status[SSF_BIT_TX_EMPTY]) |
            (n.ctrl.rx_full_irq_on & n.status[SSF_BIT_RX_FULL]);
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.status <= SSF_STATUS_RESET;
      st.ctrl <= SSF_CTRL_RESET;
      st.done_cond <= 1'b1;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= n;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign tx_data       = st.tx_data;
  assign ctrl          = st.ctrl;
  assign status        = st.status;
  assign irq_request   = st.irq;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_empty_set;
    tx_load |=> status[SSF_BIT_TX_EMPTY];
  endproperty
  a_empty_set: assert property (p_empty_set) else $error("empty flag not set on load");

  property p_empty_clear;
    !$past(rst) && $fell(status[SSF_BIT_TX_EMPTY])
      |-> $past(data_wr) && $past(st.arm[SSF_BIT_TX_EMPTY]);
  endproperty
  a_empty_clear: assert property (p_empty_clear) else $error("empty flag cleared wrongly");

  // the idle edge of the transmitter must raise the complete flag
  property p_done_set;
    status[SSF_BIT_TX_EMPTY] && !tx_busy && !$past(status[SSF_BIT_TX_EMPTY] && !tx_busy)
      |=> status[SSF_BIT_TX_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("complete flag not set");

  property p_done_clear;
    !$past(rst) && $fell(status[SSF_BIT_TX_DONE]) |-> $past(data_wr | tx_on_rise | brk_wr);
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("complete flag cleared wrongly");

  property p_full_set;
    rx.char_ready && !st.ctrl.lin_break_detect_on && !status[SSF_BIT_RX_FULL]
      |=> status[SSF_BIT_RX_FULL] && (st.rx_data == $past(rx.data));
  endproperty
  a_full_set: assert property (p_full_set) else $error("full flag or data not taken");

  property p_rx_clear;
    !$past(rst) && $fell(status[SSF_BIT_RX_FULL]) |-> $past(data_rd);
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("full flag cleared wrongly");

  property p_idle_from_start;
    rx.start_done && !st.ctrl.idle_count_select |=> st.idle_run && (st.idle_cnt == 4'h0);
  endproperty
  a_idle_from_start: assert property (p_idle_from_start) else $error("idle count not started");

  property p_idle_from_stop;
    rx.start_done && st.ctrl.idle_count_select |=> !st.idle_run;
  endproperty
  a_idle_from_stop: assert property (p_idle_from_stop) else $error("idle counted too early");

  property p_frame_set;
    rx_take && !rx.stop_bit |=> status[SSF_BIT_FRAME];
  endproperty
  a_frame_set: assert property (p_frame_set) else $error("framing error not set");

  property p_parity_off;
    rx_take && !st.ctrl.parity_on && !status[SSF_BIT_PARITY] |=> !status[SSF_BIT_PARITY];
  endproperty
  a_parity_off: assert property (p_parity_off) else $error("parity error while off");

  property p_overrun;
    rx.char_ready && !st.ctrl.lin_break_detect_on && status[SSF_BIT_RX_FULL]
      |=> status[SSF_BIT_OVERRUN] && $stable(st.rx_data);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not handled");

  property p_idle_once;
    $rose(status[SSF_BIT_IDLE]) |-> $past(st.idle_armed) ##1 !st.idle_armed;
  endproperty
  a_idle_once: assert property (p_idle_once) else $error("idle set while not armed");

  property p_status_ro;
    stat_wr && !data_rd |-> clr == 8'h00;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write cleared a flag");

  property p_lin_block;
    st.ctrl.lin_break_detect_on && rx.char_ready && !status[SSF_BIT_RX_FULL]
      |=> !status[SSF_BIT_RX_FULL] && !$rose(status[SSF_BIT_FRAME]);
  endproperty
  a_lin_block: assert property (p_lin_block) else $error("flags set under break detect");

  c_overrun: cover property (rx_lost ##1 status[SSF_BIT_OVERRUN]);
  c_idle: cover property ($rose(status[SSF_BIT_IDLE]));
  c_done_clear: cover property (stat_rd ##[1:20] $fell(status[SSF_BIT_TX_DONE]));
  c_nine_idle: cover property (st.ctrl.nine_bit_select && $rose(status[SSF_BIT_IDLE]));

endmodule

// ==== tb/ssf_remote_node.sv ====
module ssf_remote_node
  import ssf_pkg::*;
(
  // clock
  input  wire logic        clk,
  // receive events toward the flags
  output ssf_pkg::ssf_rx_t rx
);
  timeunit 1ns;
  timeprecision 1ns;

  // line rests high between frames
  initial begin
    rx = '0;
    rx.line = 1'b1;
  end

  // one bit time: strobe and tick stand for one cycle only
  task automatic bit_time(input logic lvl, input logic [6:0] smp, input logic st);
    @(posedge clk);
    rx.sample_strobe <= 1'b1;
    rx.sample_start  <= st;
    rx.samples       <= smp;
    rx.bit_tick      <= 1'b1;
    rx.line          <= lvl;
    @(posedge clk);
    rx.sample_strobe <= 1'b0;
    rx.bit_tick      <= 1'b0;
    rx.samples       <= ~smp;
  endtask

  // f[0] noisy start sample, f[1] low stop bit, f[2] wrong parity
  task automatic send_char(input logic [7:0] d, input logic [2:0] f);
    logic stop;
    stop = ~f[1];
    bit_time(1'b0, {6'h00, f[0]}, 1'b1);
    rx.start_done <= 1'b1;
    @(posedge clk);
    rx.start_done <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bit_time(d[i], {4'h0, {3{d[i]}}}, 1'b0);
    end
    bit_time(stop, {4'h0, {3{stop}}}, 1'b0);
    rx.stop_done  <= 1'b1;
    rx.char_ready <= 1'b1;
    rx.data       <= {1'b0, d};
    rx.parity_bit <= ^d ^ f[2];
    rx.stop_bit   <= stop;
    @(posedge clk);
    rx.stop_done  <= 1'b0;
    rx.char_ready <= 1'b0;
    // stale outside the valid cycle, so never the last value
    rx.data       <= ~{1'b0, d};
    rx.parity_bit <= ~(^d ^ f[2]);
    rx.stop_bit   <= ~stop;
    rx.line       <= 1'b1;
  endtask

  task automatic idle_bits(input int n);
    for (int i = 0; i < n; i++) begin
      bit_time(1'b1, 7'h07, 1'b0);
    end
  endtask
endmodule

// ==== tb/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ssf_pkg::*;

  typedef struct {
    logic [7:0] d;
    logic [2:0] f;
    logic [7:0] s;
  } ssf_tb_row_t;

  // ****************
  // signals
  // ****************
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic [3:0]       s_axi_awaddr = 4'h0;
  logic             s_axi_awvalid = 1'b0;
  logic             s_axi_awready;
  logic [31:0]      s_axi_wdata = 32'h0;
  logic [3:0]       s_axi_wstrb = 4'hf;
  logic             s_axi_wvalid = 1'b0;
  logic             s_axi_wready;
  logic [1:0]       s_axi_bresp;
  logic             s_axi_bvalid;
  logic             s_axi_bready = 1'b0;
  logic [3:0]       s_axi_araddr = 4'h0;
  logic             s_axi_arvalid = 1'b0;
  logic             s_axi_arready;
  logic [31:0]      s_axi_rdata;
  logic [1:0]       s_axi_rresp;
  logic             s_axi_rvalid;
  logic             s_axi_rready = 1'b0;
  logic             tx_load = 1'b0;
  logic             tx_busy = 1'b0;
  logic [8:0]       tx_data;
  ssf_rx_t          rx;
  ssf_ctrl_t        ctrl;
  logic [7:0]       status;
  logic             irq_request;
  logic [31:0]      rd_data;
  logic [1:0]       rd_resp;
  int               n_errors = 0;
  int               num_checks = 0;
  // character, faults, status it should leave
  ssf_tb_row_t      rows [4] = '{'{8'h55, 3'h0, 8'he0}, '{8'ha3, 3'h1, 8'he4},
                                 '{8'h10, 3'h2, 8'he2}, '{8'h7e, 3'h4, 8'he1}};

  ssf_status_flags #(.ADDR_W(4)) dut (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_load, .tx_busy, .tx_data,
    .rx, .ctrl, .status, .irq_request
  );

  ssf_remote_node node (.clk, .rx);

  always #5 clk = ~clk;

  // ****************
  // bus and checks
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  // handshakes are judged at the edge, before the design's registers move
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic more;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    more = 1'b1;
    while (more) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        more = 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic more;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    more = 1'b1;
    d = 32'h0;
    r = 2'h0;
    while (more) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        more = 1'b0;
      end
    end
  endtask

  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    rd(a, rd_data, rd_resp);
    check(rd_data, e);
    check({30'h0, rd_resp}, {30'h0, SSF_RESP_OKAY});
  endtask

  task automatic st(input logic [7:0] e);
    rc(SSF_OFF_STATUS, {24'h0, e});
  endtask

  task automatic dr(input logic [8:0] e);
    rc(SSF_OFF_DATA, {23'h0, e});
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(negedge clk);
    check({31'h0, irq_request}, {31'h0, e});
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************
  // tests
  // ****************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    st(8'hc0);
    wr(SSF_OFF_CTRL, 32'h4);
    foreach (rows[i]) begin
      node.send_char(rows[i].d, rows[i].f);
      st(rows[i].s);
      dr({1'b0, rows[i].d});
      st(8'hc0);
    end
    // overrun: second character lost, its flags never armed
    node.send_char(8'h31, 3'h0);
    st(8'he0);
    node.send_char(8'h32, 3'h2);
    wr(SSF_OFF_STATUS, 32'h0);
    dr(9'h031);
    st(8'hc8);
    dr(9'h031);
    st(8'hc0);
    rd(4'hc, rd_data, rd_resp);
    check(rd_data, 32'h0);
    check({30'h0, rd_resp}, {30'h0, SSF_RESP_DECERR});
    wr(SSF_OFF_CTRL, 32'h104);
    node.send_char(8'h00, 3'h2);
    st(8'hc0);
    // idle counted from the start bit
    wr(SSF_OFF_CTRL, 32'h0);
    node.send_char(8'hff, 3'h0);
    st(8'he0);
    node.idle_bits(1);
    st(8'hf0);
    dr(9'h0ff);
    node.idle_bits(12);
    st(8'hc0);
    // idle counted from the stop bit
    wr(SSF_OFF_CTRL, 32'h20);
    node.send_char(8'h0f, 3'h0);
    node.idle_bits(9);
    st(8'he0);
    node.idle_bits(1);
    st(8'hf0);
    dr(9'h00f);
    st(8'hc0);
    // nine-bit frames need eleven idle bits; odd parity matched by the node
    wr(SSF_OFF_CTRL, 32'h1c);
    node.send_char(8'h01, 3'h4);
    node.idle_bits(9);
    st(8'he0);
    node.idle_bits(1);
    st(8'hf0);
    dr(9'h001);
    st(8'hc0);
    wr(SSF_OFF_CTRL, 32'h0);
    // reset in mid-run with flags pending
    node.send_char(8'h44, 3'h1);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rc(SSF_OFF_CTRL, 32'h0);
    wr(SSF_OFF_DATA, 32'h0a5);
    st(8'hc0);
    wr(SSF_OFF_DATA, 32'h1a5);
    st(8'h00);
    check({23'h0, tx_data}, 32'h1a5);
    tx_busy <= 1'b1;
    tx_load <= 1'b1;
    @(posedge clk);
    tx_load <= 1'b0;
    st(8'h80);
    tx_busy <= 1'b0;
    st(8'hc0);
    wr(SSF_OFF_CTRL, 32'h2);
    st(8'h80);
    tx_busy <= 1'b1;
    @(posedge clk);
    tx_busy <= 1'b0;
    st(8'hc0);
    wr(SSF_OFF_CTRL, 32'h3);
    st(8'h80);
    wr(SSF_OFF_CTRL, 32'h40);
    irq_is(1'b1);
    wr(SSF_OFF_CTRL, 32'h80);
    irq_is(1'b0);
    node.send_char(8'h5a, 3'h0);
    irq_is(1'b1);
    give_verdict();
  end

  // the whole run is some five hundred cycles
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule
